// file: flash_ctrl_pkg.sv
package flash_ctrl_pkg;
	// special function register addresses
	localparam logic [7:0]  ERASE_CMD_ADDR  = 8'hFA;
	localparam logic [7:0]  STATUS_ADDR     = 8'hF8;
	localparam logic [7:0]  PROT_CFG_ADDR   = 8'hF9;
	// status register bit positions
	localparam int          STATUS_START_BIT = 6;
	localparam int          STATUS_WEN_BIT   = 5;
	localparam int          STATUS_NRDY_BIT  = 4;
	localparam int          STATUS_SEL_BIT   = 3;
	// configuration page offsets
	localparam logic [15:0] PARAM_AREA_SIZE = 16'h0020;
	localparam logic [15:0] INFO_CNT_OFS  = 16'h0020;
	localparam logic [15:0] INFO_RDIS_OFS = 16'h0023;
	localparam logic [15:0] INFO_DBG_OFS  = 16'h0024;
	// main block layout
	localparam logic [7:0]  PAGE_COUNT    = 8'h20;
	localparam logic [7:0]  ERASE_LIMIT   = 8'h24;
	localparam logic [15:0] CODE_SIZE     = 16'h4000;
	localparam logic [15:0] MAIN_SIZE     = 16'h4800;
	localparam logic [15:0] TOP_START     = 16'h47F0;
	localparam logic [7:0]  BYTE_FF       = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	// boot: three config bytes then sixteen top bytes
	localparam logic [4:0]  BOOT_INFO_RD  = 5'h03;
	localparam logic [4:0]  BOOT_LAST     = 5'h12;
	// cycle counts
	localparam int          WRITE_CYCLES  = 740;
	localparam int          ERASE_CYC_DEF = 360000;

	typedef enum logic [2:0] {
		OP_NONE, OP_READ, OP_PROG, OP_ERASE_PAGE, OP_ERASE_ALL, OP_ABORT
	} flash_op_type;

	typedef struct packed {
		flash_op_type op;
		logic         info;
		logic [15:0]  addr;
		logic [7:0]   wdata;
	} flash_cmd_type;

	typedef enum logic [2:0] {
		SP_READ, SP_PROG, SP_ERASE_PAGE, SP_ERASE_ALL, SP_RDIS, SP_DEBUG
	} serial_op_type;

	typedef struct packed {
		serial_op_type op;
		logic [15:0]   addr;
		logic [7:0]    wdata;
	} serial_req_type;

	typedef enum logic [2:0] {
		ST_BOOT_ADDR = 3'b000,
		ST_BOOT_DATA = 3'b001,
		ST_IDLE      = 3'b011,
		ST_BUSY      = 3'b010,
		ST_SRD       = 3'b110
	} ctrl_state_type;
endpackage : flash_ctrl_pkg

// file: flash_macro_model.sv
`timescale 1ns/10ps
module flash_macro_model
	import flash_ctrl_pkg::*;
(
	input  wire logic          sys_clk,
	input  wire flash_cmd_type flash_cmd,
	output logic [7:0]         flash_rdata
);
	logic [7:0] main_mem [int];
	logic [7:0] info_mem [int];
	logic [7:0] last_reg;
	int         aborts;

	function automatic logic [7:0] rd(input logic info, input logic [15:0] a);
		if (info)
			return info_mem.exists(a) ? info_mem[a] : BYTE_FF;
		return main_mem.exists(a) ? main_mem[a] : BYTE_FF;
	endfunction : rd

	// odd parity in top 16 bytes, four open pages, debug on
	initial begin
		aborts = 0;
		last_reg = 8'h00;
		info_mem[32'h00] = 8'h5A;
		info_mem[32'h20] = 8'h04;
		info_mem[32'h24] = 8'h00;
		main_mem[32'h47F0] = 8'h01;
	end

	// outside a read the data lines toggle so stale bytes never match
	assign flash_rdata = (flash_cmd.op == OP_READ) ? rd(flash_cmd.info, flash_cmd.addr)
		: ~last_reg;

	always @(posedge sys_clk) begin
		last_reg <= (flash_cmd.op == OP_READ) ? flash_rdata : ~last_reg;
		case (flash_cmd.op)
			OP_PROG: begin
				if (flash_cmd.info)
					info_mem[flash_cmd.addr] = rd(1'b1, flash_cmd.addr) & flash_cmd.wdata;
				else
					main_mem[flash_cmd.addr] = rd(1'b0, flash_cmd.addr) & flash_cmd.wdata;
			end
			OP_ERASE_PAGE: begin
				for (int i = 0; i < 512; i++) begin
					if (flash_cmd.info)
						info_mem.delete({flash_cmd.addr[15:9], 9'h000} + i);
					else
						main_mem.delete({flash_cmd.addr[15:9], 9'h000} + i);
				end
			end
			OP_ERASE_ALL: begin
				main_mem.delete();
				info_mem.delete();
			end
			OP_ABORT: aborts++;
			default: ;
		endcase
	end
endmodule : flash_macro_model

// file: flash_protect_and_mcu_program_ctrl.sv
`timescale 1ns/10ps
module flash_protect_and_mcu_program_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC_DEF
) (
	input  wire logic           sys_clk,
	input  wire logic           nrst,
	input  wire logic           brownout,
	input  wire logic           sfr_wr,
	input  wire logic [7:0]     sfr_addr,
	input  wire logic [7:0]     sfr_wdata,
	output logic [7:0]          sfr_rdata,
	input  wire logic           mem_wr,
	input  wire logic [15:0]    mem_addr,
	input  wire logic [7:0]     mem_wdata,
	input  wire logic           spi_valid,
	input  wire serial_req_type spi_req,
	output logic                spi_ready,
	output logic [7:0]          spi_rdata,
	output logic                spi_done,
	output logic                spi_denied,
	output flash_cmd_type       flash_cmd,
	input  wire logic [7:0]     flash_rdata,
	output logic                mcu_stall,
	output logic [15:0]         start_addr,
	output logic                debug_enable,
	output logic                chip_reset_req
);
	ctrl_state_type state_reg, state_next;
	flash_cmd_type  cmd_reg, cmd_next;
	logic [18:0]    busy_cnt_reg, busy_cnt_next;
	logic [4:0]     boot_idx_reg;
	logic           parity_reg;
	logic [7:0]     count_reg, rdis_reg, dbg_reg, erase_cmd_reg;
	logic           start_sel_reg, wen_reg, page_sel_reg, spi_own_reg, prog_reg;
	logic [7:0]     sfr_rdata_reg, spi_rdata_reg;
	logic           spi_done_reg, spi_denied_reg, dbg_en_reg, reset_req_reg;
	logic [15:0]    start_addr_reg;
	logic [18:0]    stall_len_reg;

	wire idle = (state_reg == ST_IDLE);
	wire busy = (state_reg == ST_BUSY);
	wire prot_on = (count_reg < PAGE_COUNT);
	wire mem_prot = prot_on && (mem_addr < CODE_SIZE)
		&& ({3'b000, mem_addr[13:9]} >= count_reg);
	wire top_rsv = (count_reg != BYTE_FF) && (mem_addr >= TOP_START);
	wire mcu_wr_ok = mem_wr && idle && wen_reg && (mem_addr < MAIN_SIZE)
		&& !mem_prot && !top_rsv && !brownout;
	wire erase_cmd_wr = sfr_wr && (sfr_addr == ERASE_CMD_ADDR);
	wire status_wr = sfr_wr && (sfr_addr == STATUS_ADDR);
	wire erase_prot = prot_on && (sfr_wdata < PAGE_COUNT) && (sfr_wdata >= count_reg);
	wire mcu_er_ok = erase_cmd_wr && idle && wen_reg && (sfr_wdata < ERASE_LIMIT)
		&& !erase_prot && !brownout;
	wire [15:0] erase_base = {sfr_wdata[6:0], 9'h000};
	// core requests take priority; serial port waits
	assign spi_ready = idle && !mem_wr && !erase_cmd_wr;
	wire spi_take = spi_valid && spi_ready && !brownout;
	wire locked = (rdis_reg != BYTE_FF);
	wire spi_ok = (spi_req.op == SP_READ) ? (!locked || page_sel_reg) :
		(spi_req.op == SP_ERASE_ALL) ? wen_reg : (wen_reg && !locked);
	wire spi_go = spi_take && spi_ok;
	wire boot_info = (boot_idx_reg < BOOT_INFO_RD);
	wire [15:0] boot_addr = (boot_idx_reg == 5'h00) ? INFO_CNT_OFS :
		(boot_idx_reg == 5'h01) ? INFO_RDIS_OFS :
		(boot_idx_reg == 5'h02) ? INFO_DBG_OFS :
		TOP_START + {11'h000, boot_idx_reg - BOOT_INFO_RD};
	wire rd_parity = ^flash_rdata;

	always_comb begin
		state_next = state_reg;
		cmd_next = '0;
		busy_cnt_next = busy_cnt_reg;
		case (state_reg)
			ST_BOOT_ADDR: begin
				cmd_next = '{OP_READ, boot_info, boot_addr, BYTE_ZERO};
				state_next = ST_BOOT_DATA;
			end
			ST_BOOT_DATA: begin
				state_next = (boot_idx_reg == BOOT_LAST) ? ST_IDLE : ST_BOOT_ADDR;
			end
			ST_IDLE: begin
				if (mcu_wr_ok) begin
					cmd_next = '{OP_PROG, 1'b0, mem_addr, mem_wdata};
					busy_cnt_next = 19'(WRITE_CYCLES - 1);
					state_next = ST_BUSY;
				end else if (mcu_er_ok) begin
					cmd_next = '{OP_ERASE_PAGE, 1'b0, erase_base, BYTE_ZERO};
					busy_cnt_next = 19'(ERASE_CYCLES - 1);
					state_next = ST_BUSY;
				end else if (spi_go) begin
					busy_cnt_next = 19'(WRITE_CYCLES - 1);
					state_next = ST_BUSY;
					case (spi_req.op)
						SP_READ: begin
							cmd_next = '{OP_READ, page_sel_reg, spi_req.addr, BYTE_ZERO};
							state_next = ST_SRD;
						end
						// config page reached only with select set
						SP_PROG: cmd_next = '{OP_PROG, page_sel_reg, spi_req.addr, spi_req.wdata};
						SP_ERASE_PAGE: begin
							cmd_next = '{OP_ERASE_PAGE, page_sel_reg, spi_req.addr, BYTE_ZERO};
							busy_cnt_next = 19'(ERASE_CYCLES - 1);
						end
						// wipes main block and config page
						SP_ERASE_ALL: begin
							cmd_next = '{OP_ERASE_ALL, 1'b1, 16'h0000, BYTE_ZERO};
							busy_cnt_next = 19'(ERASE_CYCLES - 1);
						end
						SP_RDIS: cmd_next = '{OP_PROG, 1'b1, INFO_RDIS_OFS, BYTE_ZERO};
						SP_DEBUG: cmd_next = '{OP_PROG, 1'b1, INFO_DBG_OFS, BYTE_ZERO};
						default: state_next = ST_IDLE;
					endcase
				end
			end
			ST_BUSY: begin
				if (busy_cnt_reg == 19'h00000)
					state_next = ST_IDLE;
				else
					busy_cnt_next = busy_cnt_reg - 19'h00001;
			end
			ST_SRD: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (brownout && busy) begin
			cmd_next = '0;
			cmd_next.op = OP_ABORT;
			state_next = ST_IDLE;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_BOOT_ADDR;
			cmd_reg <= '0;
			busy_cnt_reg <= 19'h00000;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			busy_cnt_reg <= busy_cnt_next;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_idx_reg <= 5'h00;
			parity_reg <= 1'b0;
			start_sel_reg <= 1'b0;
		end else if (state_reg == ST_BOOT_DATA) begin
			boot_idx_reg <= boot_idx_reg + 5'h01;
			if (!boot_info)
				parity_reg <= parity_reg ^ rd_parity;
			if (boot_idx_reg == BOOT_LAST)
				start_sel_reg <= parity_reg ^ rd_parity;
		end
	end

	// configuration bytes; erase-all returns them to blank
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= BYTE_FF;
			rdis_reg <= BYTE_FF;
			dbg_reg <= BYTE_FF;
		end else if (state_reg == ST_BOOT_DATA) begin
			if (boot_idx_reg == 5'h00)
				count_reg <= flash_rdata;
			if (boot_idx_reg == 5'h01)
				rdis_reg <= flash_rdata;
			if (boot_idx_reg == 5'h02)
				dbg_reg <= flash_rdata;
		end else if (spi_go) begin
			if (spi_req.op == SP_ERASE_ALL) begin
				count_reg <= BYTE_FF;
				rdis_reg <= BYTE_FF;
				dbg_reg <= BYTE_FF;
			end
			if (spi_req.op == SP_RDIS)
				rdis_reg <= BYTE_ZERO;
			if (spi_req.op == SP_DEBUG)
				dbg_reg <= BYTE_ZERO;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wen_reg <= 1'b0;
			page_sel_reg <= 1'b0;
			erase_cmd_reg <= BYTE_ZERO;
		end else begin
			// enable stays until software drops it
			if (status_wr) begin
				wen_reg <= sfr_wdata[STATUS_WEN_BIT];
				page_sel_reg <= sfr_wdata[STATUS_SEL_BIT];
			end
			if (erase_cmd_wr)
				erase_cmd_reg <= sfr_wdata;
		end
	end

	wire [7:0] status_val = {1'b0, start_sel_reg, wen_reg, !idle, page_sel_reg, 3'b000};
	wire [7:0] sfr_mux = (sfr_addr == STATUS_ADDR) ? status_val :
		(sfr_addr == PROT_CFG_ADDR) ? {1'b0, count_reg[6:0]} :
		(sfr_addr == ERASE_CMD_ADDR) ? erase_cmd_reg : BYTE_ZERO;
	wire spi_end = (state_reg == ST_SRD) || (busy && busy_cnt_reg == 19'h00000 && spi_own_reg);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sfr_rdata_reg <= BYTE_ZERO;
			spi_rdata_reg <= BYTE_ZERO;
			spi_done_reg <= 1'b0;
			spi_denied_reg <= 1'b0;
			spi_own_reg <= 1'b0;
			prog_reg <= 1'b0;
			start_addr_reg <= 16'h0000;
			dbg_en_reg <= 1'b0;
			reset_req_reg <= 1'b0;
		end else begin
			sfr_rdata_reg <= sfr_mux;
			if (state_reg == ST_SRD)
				spi_rdata_reg <= flash_rdata;
			spi_done_reg <= spi_end || (spi_take && !spi_ok);
			spi_denied_reg <= spi_take && !spi_ok;
			if (idle)
				spi_own_reg <= spi_go;
			if (idle)
				prog_reg <= (cmd_next.op == OP_PROG);
			// start of protected area or zero
			start_addr_reg <= (start_sel_reg && prot_on) ? {2'b00, count_reg[4:0], 9'h000}
				: 16'h0000;
			dbg_en_reg <= (dbg_reg != BYTE_FF);
			reset_req_reg <= brownout;
		end
	end

	assign sfr_rdata = sfr_rdata_reg;
	assign spi_rdata = spi_rdata_reg;
	assign spi_done = spi_done_reg;
	assign spi_denied = spi_denied_reg;
	assign flash_cmd = cmd_reg;
	assign mcu_stall = !idle;
	assign start_addr = start_addr_reg;
	assign debug_enable = dbg_en_reg;
	assign chip_reset_req = reset_req_reg;

	// assertion helper: length of each busy period
	localparam int WR_LEN = WRITE_CYCLES;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			stall_len_reg <= 19'h00000;
		else
			stall_len_reg <= busy ? stall_len_reg + 19'h00001 : 19'h00000;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence write_go;
		mcu_wr_ok;
	endsequence
	sequence held_stall;
		mcu_stall [*8];
	endsequence

	AST_WRITE_HOLD: assert property (write_go |=> held_stall)
		else $error("core not stalled after byte write");
	AST_WRITE_LEN: assert property (busy && busy_cnt_reg == 19'h00000 && prog_reg
		&& !spi_own_reg |-> stall_len_reg == 19'(WR_LEN - 1))
		else $error("byte write stall length wrong");
	AST_PROT_WRITE: assert property (mem_wr && mem_prot |=> cmd_reg.op != OP_PROG)
		else $error("protected page written by core");
	AST_WEN_ERASE: assert property (erase_cmd_wr && !wen_reg |=> cmd_reg.op != OP_ERASE_PAGE)
		else $error("erase without write enable");
	AST_ERASE_PAGE: assert property (mcu_er_ok |=> cmd_reg.op == OP_ERASE_PAGE
		&& cmd_reg.addr == {$past(sfr_wdata[6:0]), 9'h000})
		else $error("erase issued to wrong page");
	AST_LOCK_DENY: assert property (spi_take && locked && !page_sel_reg
		&& spi_req.op != SP_ERASE_ALL |=> spi_denied)
		else $error("locked main block reached by serial port");
	AST_UNLOCK: assert property (spi_go && spi_req.op == SP_ERASE_ALL |=> !locked)
		else $error("full erase left lock in place");
	AST_BROWNOUT: assert property (brownout && busy |=> cmd_reg.op == OP_ABORT
		&& chip_reset_req)
		else $error("brown-out did not abort and reset");
	AST_PARAM_GUARD: assert property (cmd_reg.op == OP_PROG && cmd_reg.info
		&& cmd_reg.addr < PARAM_AREA_SIZE |-> $past(page_sel_reg))
		else $error("device area programmed without select");
	AST_BOOT_STP: assert property (state_reg == ST_BOOT_DATA
		&& boot_idx_reg == BOOT_LAST |=> start_sel_reg == ($past(parity_reg) ^ $past(rd_parity)))
		else $error("start select parity wrong");
endmodule : flash_protect_and_mcu_program_ctrl

// file: flash_protect_and_mcu_program_ctrl_tb_top.sv
`timescale 1ns/10ps
module flash_protect_and_mcu_program_ctrl_tb_top
	import flash_ctrl_pkg::*;
;
	logic           sys_clk, nrst, brownout, sfr_wr, mem_wr, spi_valid;
	logic [7:0]     sfr_addr, sfr_wdata, sfr_rdata, mem_wdata, spi_rdata, flash_rdata;
	logic [15:0]    mem_addr, start_addr;
	serial_req_type spi_req;
	flash_cmd_type  flash_cmd;
	logic           spi_ready, spi_done, spi_denied, mcu_stall, debug_enable, chip_reset_req;
	int             miscompares, total_checks;

	flash_protect_and_mcu_program_ctrl #(.ERASE_CYCLES(20)) i_dut (.sys_clk(sys_clk),
		.nrst(nrst), .brownout(brownout), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .spi_valid(spi_valid), .spi_req(spi_req),
		.spi_ready(spi_ready), .spi_rdata(spi_rdata), .spi_done(spi_done),
		.spi_denied(spi_denied), .flash_cmd(flash_cmd), .flash_rdata(flash_rdata),
		.mcu_stall(mcu_stall), .start_addr(start_addr), .debug_enable(debug_enable),
		.chip_reset_req(chip_reset_req));
	flash_macro_model i_flash (.sys_clk(sys_clk), .flash_cmd(flash_cmd),
		.flash_rdata(flash_rdata));

	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic hang();
		miscompares++;
		$display("Error at %0t: wait limit reached", $time);
		report_and_stop();
	endtask : hang

	// stall cycles seen after a write strobe; zero means refused
	task automatic mcu_op(input logic is_mem, input logic [15:0] a, input logic [7:0] d,
		output int n);
		@(posedge sys_clk);
		mem_wr <= is_mem;
		sfr_wr <= ~is_mem;
		mem_addr <= a;
		sfr_addr <= a[7:0];
		mem_wdata <= d;
		sfr_wdata <= d;
		@(posedge sys_clk);
		mem_wr <= 1'b0;
		sfr_wr <= 1'b0;
		n = 0;
		for (int i = 0; i < 1000; i++) begin
			@(negedge sys_clk);
			if (mcu_stall !== 1'b1)
				return;
			n++;
		end
		hang();
	endtask : mcu_op

	task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		sfr_addr <= a;
		@(posedge sys_clk);
		@(negedge sys_clk);
		v = sfr_rdata;
	endtask : sfr_read

	task automatic spi_op(input serial_op_type op, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] v, output logic den);
		logic taken;
		taken = 1'b0;
		@(posedge sys_clk);
		spi_valid <= 1'b1;
		spi_req <= '{op: op, addr: a, wdata: d};
		for (int i = 0; i < 100 && !taken; i++) begin
			@(negedge sys_clk);
			taken = (spi_ready === 1'b1);
			@(posedge sys_clk);
		end
		spi_valid <= 1'b0;
		if (!taken)
			hang();
		for (int i = 0; i < 1000; i++) begin
			@(negedge sys_clk);
			if (spi_done === 1'b1) begin
				v = spi_rdata;
				den = spi_denied;
				return;
			end
		end
		hang();
	endtask : spi_op

	task automatic do_reset();
		@(posedge sys_clk);
		nrst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 200; i++) begin
			@(negedge sys_clk);
			if (mcu_stall === 1'b0)
				return;
		end
		hang();
	endtask : do_reset

	task automatic test_boot(input logic [15:0] sa, input logic dbg, input logic [7:0] cnt);
		logic [7:0] v;
		// start address is registered one cycle after boot ends
		@(negedge sys_clk);
		check(start_addr, sa);
		check(debug_enable, dbg);
		sfr_read(PROT_CFG_ADDR, v);
		check(v, cnt);
		sfr_read(ERASE_CMD_ADDR, v);
		check(v, 8'h00);
		$display("boot test done");
	endtask : test_boot

	task automatic test_core_write();
		int n;
		mcu_op(1'b0, STATUS_ADDR, 8'h00, n);
		mcu_op(1'b1, 16'h0600, 8'h3C, n);
		check(i_flash.rd(1'b0, 16'h0600), 8'hFF);
		mcu_op(1'b0, STATUS_ADDR, 8'h20, n);
		mcu_op(1'b1, 16'h0800, 8'h3C, n);
		check(n, 0);
		check(i_flash.rd(1'b0, 16'h0800), 8'hFF);
		mcu_op(1'b1, 16'h0600, 8'h3C, n);
		check(n, 740);
		check(i_flash.rd(1'b0, 16'h0600), 8'h3C);
		check(i_flash.rd(1'b0, 16'h0601), 8'hFF);
		$display("core write test done");
	endtask : test_core_write

	task automatic test_erase_table();
		logic [7:0] pg [6] = '{8'h03, 8'h05, 8'h1F, 8'h20, 8'h23, 8'h24};
		int         ex [6] = '{20, 0, 0, 20, 20, 0};
		int         n;
		foreach (pg[i]) begin
			mcu_op(1'b0, ERASE_CMD_ADDR, pg[i], n);
			check(n, ex[i]);
		end
		check(i_flash.rd(1'b0, 16'h0600), 8'hFF);
		$display("erase test done");
	endtask : test_erase_table

	task automatic test_brownout();
		repeat (2) @(posedge sys_clk);
		mem_wr <= 1'b1;
		mem_addr <= 16'h0610;
		@(posedge sys_clk);
		mem_wr <= 1'b0;
		// past the eight-cycle stall window that the hold check covers
		repeat (10) @(posedge sys_clk);
		brownout <= 1'b1;
		repeat (3) @(negedge sys_clk);
		check(i_flash.aborts, 1);
		check(chip_reset_req, 1'b1);
		@(posedge sys_clk);
		brownout <= 1'b0;
		do_reset();
		$display("brownout test done");
	endtask : test_brownout

	task automatic test_serial_lock();
		logic [7:0] v, keep;
		logic       den;
		int         n;
		mcu_op(1'b0, STATUS_ADDR, 8'h20, n);
		spi_op(SP_RDIS, 16'h0000, 8'h00, v, den);
		spi_op(SP_READ, 16'h0000, 8'h00, v, den);
		check(den, 1'b1);
		mcu_op(1'b0, STATUS_ADDR, 8'h28, n);
		spi_op(SP_READ, 16'h0000, 8'h00, keep, den);
		check({den, keep}, 9'h05A);
		spi_op(SP_ERASE_ALL, 16'h0000, 8'h00, v, den);
		check(i_flash.rd(1'b1, 16'h0000), 8'hFF);
		mcu_op(1'b0, STATUS_ADDR, 8'h20, n);
		spi_op(SP_READ, 16'h0000, 8'h00, v, den);
		check(den, 1'b0);
		mcu_op(1'b0, STATUS_ADDR, 8'h28, n);
		spi_op(SP_PROG, 16'h0000, keep, v, den);
		check(i_flash.rd(1'b1, 16'h0000), 8'h5A);
		do_reset();
		test_boot(16'h0000, 1'b0, 8'h7F);
		mcu_op(1'b0, STATUS_ADDR, 8'h20, n);
		mcu_op(1'b0, ERASE_CMD_ADDR, 8'h1F, n);
		check(n, 20);
		spi_op(SP_RDIS, 16'h0000, 8'h00, v, den);
		spi_op(SP_READ, 16'h0000, 8'h00, v, den);
		check(den, 1'b1);
		$display("serial lock test done");
	endtask : test_serial_lock

	initial begin
		miscompares = 0;
		total_checks = 0;
		{nrst, brownout, sfr_wr, mem_wr, spi_valid} = '0;
		{sfr_addr, sfr_wdata, mem_wdata, mem_addr} = '0;
		spi_req = '0;
		do_reset();
		// odd top parity moves start to page 4
		test_boot(16'h0800, 1'b1, 8'h04);
		test_core_write();
		test_erase_table();
		test_brownout();
		test_serial_lock();
		report_and_stop();
	end
endmodule : flash_protect_and_mcu_program_ctrl_tb_top
